// [src/dopm_output_mux.v]
// Purpose: output pin multiplexer and per-channel mode register pointer
// Assumes: single clock; register writes arrive as one-cycle strobes
// Notes:   pins are registered, so each follows its source one cycle late
`timescale 1ns/1ps
`include "dopm_consts.vh"

module dopm_output_mux #(
  parameter DW = 8
) (
  // clock and reset
  input  wire          clk_sys,
  input  wire          reset,
  // channel A mode register access
  input  wire          mode_wr_chan_a,
  input  wire          mode_rd_chan_a,
  input  wire [DW-1:0] mode_wdata_chan_a,
  output wire [DW-1:0] mode_rdata_chan_a,
  output wire          mode_ptr_chan_a,
  // channel B mode register access
  input  wire          mode_wr_chan_b,
  input  wire          mode_rd_chan_b,
  input  wire [DW-1:0] mode_wdata_chan_b,
  output wire [DW-1:0] mode_rdata_chan_b,
  output wire          mode_ptr_chan_b,
  // command registers
  input  wire          cmd_wr_chan_a,
  input  wire          cmd_wr_chan_b,
  input  wire [DW-1:0] cmd_wdata,
  // clock select registers
  input  wire          csr_wr_chan_a,
  input  wire          csr_wr_chan_b,
  input  wire [DW-1:0] csr_wdata,
  output wire [DW-1:0] clock_select_chan_a,
  output wire [DW-1:0] clock_select_chan_b,
  // configuration registers
  input  wire          output_pin_config_reg_wr,
  input  wire [DW-1:0] output_pin_config_reg_wdata,
  input  wire          acr_wr,
  input  wire [DW-1:0] acr_wdata,
  input  wire          opr_set,
  input  wire          opr_clr,
  input  wire [DW-1:0] opr_bits,
  output wire [DW-1:0] output_pin_config,
  output wire [DW-1:0] aux_control,
  output wire [DW-1:0] output_latch,
  // full mode register views
  output wire [DW-1:0] mode_one_chan_a,
  output wire [DW-1:0] mode_two_chan_a,
  output wire [DW-1:0] mode_one_chan_b,
  output wire [DW-1:0] mode_two_chan_b,
  // internal sources
  input  wire          rx_ready_chan_a,
  input  wire          rx_ready_chan_b,
  input  wire          rx_fifo_full_chan_a,
  input  wire          rx_fifo_full_chan_b,
  input  wire          tx_ready_chan_a,
  input  wire          tx_ready_chan_b,
  input  wire          rx_rts_chan_a,
  input  wire          tx_rts_chan_a,
  input  wire          rx_rts_chan_b,
  input  wire          tx_rts_chan_b,
  input  wire          counter_ready_out,
  input  wire          timer_out,
  input  wire          tx_clock_chan_a_16x,
  input  wire          tx_clock_chan_a,
  input  wire          rx_clock_chan_a,
  input  wire          tx_clock_chan_b,
  input  wire          rx_clock_chan_b,
  // parallel output pins
  output wire [7:0]    out_pins
);

  reg  [DW-1:0] clock_select_reg_a;
  reg  [DW-1:0] clock_select_reg_b;
  reg  [DW-1:0] output_pin_config_reg;
  reg  [DW-1:0] aux_control_reg;
  reg  [DW-1:0] output_latch_reg;
  reg  [7:0]    pins_reg;
  reg  [7:0]    pins_next;

  // mode register contents from the two channel slices
  wire [DW-1:0] mode_reg_one_chan_a;
  wire [DW-1:0] mode_reg_two_chan_a;
  wire [DW-1:0] mode_reg_one_chan_b;
  wire [DW-1:0] mode_reg_two_chan_b;

  dopm_mode_chan #(
    .DW         (DW)
  ) dopm_mode_chan_a_i (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .mode_wr    (mode_wr_chan_a),
    .mode_rd    (mode_rd_chan_a),
    .mode_wdata (mode_wdata_chan_a),
    .mode_rdata (mode_rdata_chan_a),
    .cmd_wr     (cmd_wr_chan_a),
    .cmd_wdata  (cmd_wdata),
    .mode_ptr   (mode_ptr_chan_a),
    .mode_one   (mode_reg_one_chan_a),
    .mode_two   (mode_reg_two_chan_a)
  );

  // the command byte is shared; only the strobe tells the channels apart
  dopm_mode_chan #(
    .DW         (DW)
  ) dopm_mode_chan_b_i (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .mode_wr    (mode_wr_chan_b),
    .mode_rd    (mode_rd_chan_b),
    .mode_wdata (mode_wdata_chan_b),
    .mode_rdata (mode_rdata_chan_b),
    .cmd_wr     (cmd_wr_chan_b),
    .cmd_wdata  (cmd_wdata),
    .mode_ptr   (mode_ptr_chan_b),
    .mode_one   (mode_reg_one_chan_b),
    .mode_two   (mode_reg_two_chan_b)
  );

  always @(posedge clk_sys) begin
    if (reset) begin
      clock_select_reg_a <= `DOPM_CSR_RESET;
      clock_select_reg_b <= `DOPM_CSR_RESET;
    end else begin
      if (csr_wr_chan_a)
        clock_select_reg_a <= csr_wdata;
      if (csr_wr_chan_b)
        clock_select_reg_b <= csr_wdata;
    end
  end

  // shared configuration and latch; set wins over reset of a bit
  always @(posedge clk_sys) begin
    if (reset) begin
      output_pin_config_reg <= `DOPM_OUTPUT_PIN_CONFIG_REG_RESET;
      aux_control_reg       <= `DOPM_ACR_RESET;
      output_latch_reg      <= `DOPM_OPR_RESET;
    end else begin
      if (output_pin_config_reg_wr)
        output_pin_config_reg <= output_pin_config_reg_wdata;
      if (acr_wr)
        aux_control_reg <= acr_wdata;
      if (opr_set || opr_clr)
        output_latch_reg <= (output_latch_reg &
                             ~(opr_clr ? opr_bits : {DW{1'b0}})) |
                            (opr_set ? opr_bits : {DW{1'b0}});
    end
  end

  // pin selection; pins with no source selected fall back to the latch
  always @* begin
    pins_next = output_latch_reg[7:0];
    if (mode_reg_one_chan_a[`DOPM_MR1_RX_RTS_BIT] ||
        mode_reg_two_chan_a[`DOPM_MR2_TX_RTS_BIT])
      pins_next[0] = (mode_reg_one_chan_a[`DOPM_MR1_RX_RTS_BIT] &
                      rx_rts_chan_a) |
                     (mode_reg_two_chan_a[`DOPM_MR2_TX_RTS_BIT] &
                      tx_rts_chan_a);
    if (mode_reg_one_chan_b[`DOPM_MR1_RX_RTS_BIT] ||
        mode_reg_two_chan_b[`DOPM_MR2_TX_RTS_BIT])
      pins_next[1] = (mode_reg_one_chan_b[`DOPM_MR1_RX_RTS_BIT] &
                      rx_rts_chan_b) |
                     (mode_reg_two_chan_b[`DOPM_MR2_TX_RTS_BIT] &
                      tx_rts_chan_b);
    case (output_pin_config_reg[`DOPM_OUTPUT_PIN_CONFIG_REG_P2_LO+1:`DOPM_OUTPUT_PIN_CONFIG_REG_P2_LO])
      `DOPM_SEL_01: pins_next[2] = tx_clock_chan_a_16x;
      `DOPM_SEL_10: pins_next[2] = tx_clock_chan_a;
      `DOPM_SEL_11: pins_next[2] = rx_clock_chan_a;
      default:      pins_next[2] = output_latch_reg[2];
    endcase
    case (output_pin_config_reg[`DOPM_OUTPUT_PIN_CONFIG_REG_P3_LO+1:`DOPM_OUTPUT_PIN_CONFIG_REG_P3_LO])
      `DOPM_SEL_01: pins_next[3] = aux_control_reg[`DOPM_ACR_TIMER_BIT] ?
                                   timer_out : counter_ready_out;
      `DOPM_SEL_10: pins_next[3] = tx_clock_chan_b;
      `DOPM_SEL_11: pins_next[3] = rx_clock_chan_b;
      default:      pins_next[3] = output_latch_reg[3];
    endcase
    if (output_pin_config_reg[`DOPM_OUTPUT_PIN_CONFIG_REG_P4_BIT])
      pins_next[4] = mode_reg_one_chan_a[`DOPM_MR1_RX_IRQ_BIT] ?
                     rx_fifo_full_chan_a : rx_ready_chan_a;
    if (output_pin_config_reg[`DOPM_OUTPUT_PIN_CONFIG_REG_P5_BIT])
      pins_next[5] = mode_reg_one_chan_b[`DOPM_MR1_RX_IRQ_BIT] ?
                     rx_fifo_full_chan_b : rx_ready_chan_b;
    if (output_pin_config_reg[`DOPM_OUTPUT_PIN_CONFIG_REG_P6_BIT])
      pins_next[6] = tx_ready_chan_a;
    if (output_pin_config_reg[`DOPM_OUTPUT_PIN_CONFIG_REG_P7_BIT])
      pins_next[7] = tx_ready_chan_b;
  end

  // registered pins avoid glitches while selections change
  always @(posedge clk_sys) begin
    if (reset)
      pins_reg <= 8'h00;
    else
      pins_reg <= pins_next;
  end

  // register views straight from their flops
  assign clock_select_chan_a = clock_select_reg_a;
  assign clock_select_chan_b = clock_select_reg_b;
  assign output_pin_config   = output_pin_config_reg;
  assign aux_control         = aux_control_reg;
  assign output_latch        = output_latch_reg;
  assign mode_one_chan_a     = mode_reg_one_chan_a;
  assign mode_two_chan_a     = mode_reg_two_chan_a;
  assign mode_one_chan_b     = mode_reg_one_chan_b;
  assign mode_two_chan_b     = mode_reg_two_chan_b;
  assign out_pins            = pins_reg;

endmodule

// one channel's mode register pair and its access pointer; the pointer
// picks register one after reset and register two after the first access
module dopm_mode_chan #(
  parameter DW = 8
) (
  // clock and reset
  input  wire          clk_sys,
  input  wire          reset,
  // mode register access
  input  wire          mode_wr,
  input  wire          mode_rd,
  input  wire [DW-1:0] mode_wdata,
  output wire [DW-1:0] mode_rdata,
  // command register write
  input  wire          cmd_wr,
  input  wire [DW-1:0] cmd_wdata,
  // pointer and register views
  output wire          mode_ptr,
  output wire [DW-1:0] mode_one,
  output wire [DW-1:0] mode_two
);

  reg  [DW-1:0] mode_one_reg;
  reg  [DW-1:0] mode_two_reg;
  reg           ptr_reg;
  reg           ptr_next;

  wire          access;
  wire          ptr_cmd;

  assign access = mode_wr | mode_rd;
  // pointer reset code; other misc codes leave the pointer alone
  assign ptr_cmd = cmd_wr &&
                   (cmd_wdata[`DOPM_CMD_MISC_HI:`DOPM_CMD_MISC_LO] ==
                    `DOPM_CMD_RESET_PTR);

  // pointer next state; a reset command beats a same-cycle access
  always @* begin
    ptr_next = ptr_reg;
    if (access)
      ptr_next = 1'b1;
    if (ptr_cmd)
      ptr_next = 1'b0;
  end

  always @(posedge clk_sys) begin
    if (reset)
      ptr_reg <= 1'b0;
    else
      ptr_reg <= ptr_next;
  end

  // writes steer by the pointer as it stood before the access
  always @(posedge clk_sys) begin
    if (reset) begin
      mode_one_reg <= `DOPM_MR_RESET;
      mode_two_reg <= `DOPM_MR_RESET;
    end else begin
      if (mode_wr && !ptr_reg)
        mode_one_reg <= mode_wdata;
      if (mode_wr && ptr_reg)
        mode_two_reg <= mode_wdata;
    end
  end

  assign mode_rdata = ptr_reg ? mode_two_reg : mode_one_reg;
  assign mode_ptr   = ptr_reg;
  assign mode_one   = mode_one_reg;
  assign mode_two   = mode_two_reg;

endmodule

// [src/dopm_consts.vh]
// Purpose: constants for the output port mux and mode pointer block
// Assumes: eight-bit configuration and mode registers
// Notes:   field positions are bit indices within each register
`ifndef DOPM_CONSTS_VH
`define DOPM_CONSTS_VH

// mode register one fields
`define DOPM_MR1_RX_RTS_BIT    7
`define DOPM_MR1_RX_IRQ_BIT    6
// mode register two fields
`define DOPM_MR2_TX_RTS_BIT    5
// aux control fields
`define DOPM_ACR_TIMER_BIT     6
// output pin config fields
`define DOPM_OUTPUT_PIN_CONFIG_REG_P2_LO        0
`define DOPM_OUTPUT_PIN_CONFIG_REG_P3_LO        2
`define DOPM_OUTPUT_PIN_CONFIG_REG_P4_BIT       4
`define DOPM_OUTPUT_PIN_CONFIG_REG_P5_BIT       5
`define DOPM_OUTPUT_PIN_CONFIG_REG_P6_BIT       6
`define DOPM_OUTPUT_PIN_CONFIG_REG_P7_BIT       7
// two-bit pin select codes
`define DOPM_SEL_GP            2'h0
`define DOPM_SEL_01            2'h1
`define DOPM_SEL_10            2'h2
`define DOPM_SEL_11            2'h3
// command register misc field
`define DOPM_CMD_MISC_HI       6
`define DOPM_CMD_MISC_LO       4
`define DOPM_CMD_RESET_PTR     3'h1
// reset values
`define DOPM_MR_RESET          8'h00
`define DOPM_OUTPUT_PIN_CONFIG_REG_RESET        8'h00
`define DOPM_ACR_RESET         8'h00
`define DOPM_CSR_RESET         8'h00
`define DOPM_OPR_RESET         8'h00

`endif

// [verification/dopm_checker_sva.sv]
// Purpose: assertions on the output pin mux and channel a mode pointer
// Assumes: pins are registered, one clock behind their sources
// Notes:   sees top ports only; pin levels rebuilt from config and sources
`timescale 1ns/1ps
module dopm_checker (
  // clock, reset and channel a pointer controls
  input wire logic clk_sys, reset, mode_wr_chan_a, mode_rd_chan_a,
  input wire logic cmd_wr_chan_a, mode_ptr_chan_a,
  // pin sources
  input wire logic rx_ready_chan_a, rx_ready_chan_b, rx_fifo_full_chan_a,
  input wire logic rx_fifo_full_chan_b, tx_ready_chan_a, tx_ready_chan_b,
  input wire logic rx_rts_chan_a, tx_rts_chan_a, rx_rts_chan_b, timer_out,
  input wire logic tx_rts_chan_b, counter_ready_out, tx_clock_chan_a_16x,
  input wire logic tx_clock_chan_a, rx_clock_chan_a, tx_clock_chan_b,
  input wire logic rx_clock_chan_b,
  // registers and pins
  input wire logic [7:0] cmd_wdata, output_pin_config, aux_control,
  input wire logic [7:0] output_latch, mode_one_chan_a, mode_two_chan_a,
  input wire logic [7:0] mode_one_chan_b, mode_two_chan_b, out_pins
);
  logic [7:0] e;
  wire  [7:0] c = output_pin_config;
  wire  [7:0] l = output_latch;
  wire        ra = mode_one_chan_a[7] | mode_two_chan_a[5];
  wire        rb = mode_one_chan_b[7] | mode_two_chan_b[5];
  // expected levels; a pin shows them one clock later since pins are flops
  always_comb begin
    e[0] = ra ? (rx_rts_chan_a & mode_one_chan_a[7])
              | (tx_rts_chan_a & mode_two_chan_a[5]) : l[0];
    e[1] = rb ? (rx_rts_chan_b & mode_one_chan_b[7])
              | (tx_rts_chan_b & mode_two_chan_b[5]) : l[1];
    e[2] = c[1] ? (c[0] ? rx_clock_chan_a : tx_clock_chan_a)
                : (c[0] ? tx_clock_chan_a_16x : l[2]);
    e[3] = c[3] ? (c[2] ? rx_clock_chan_b : tx_clock_chan_b)
                : (c[2] ? (aux_control[6] ? timer_out : counter_ready_out)
                        : l[3]);
    e[4] = c[4] ? (mode_one_chan_a[6] ? rx_fifo_full_chan_a
                                      : rx_ready_chan_a) : l[4];
    e[5] = c[5] ? (mode_one_chan_b[6] ? rx_fifo_full_chan_b
                                      : rx_ready_chan_b) : l[5];
    e[6] = c[6] ? tx_ready_chan_a : l[6];
    e[7] = c[7] ? tx_ready_chan_b : l[7];
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // the clock after reset still sees pins cleared by reset
  sequence run; !$past(reset); endsequence
  sequence ptr_cmd_a; cmd_wr_chan_a && cmd_wdata[6:4] == 3'h1; endsequence
  sequence acc_one_a;
    !mode_ptr_chan_a && !cmd_wr_chan_a ##0 (mode_wr_chan_a || mode_rd_chan_a);
  endsequence
  rts_pins_a: assert property (run |-> out_pins[1:0] == $past(e[1:0]))
    else $error("pins 0 and 1 wrong");
  pin_two_a: assert property (run |-> out_pins[2] == $past(e[2]))
    else $error("pin 2 wrong");
  pin_three_a: assert property (run |-> out_pins[3] == $past(e[3]))
    else $error("pin 3 wrong");
  pin_four_a: assert property (run |-> out_pins[4] == $past(e[4]))
    else $error("pin 4 wrong");
  pin_five_a: assert property (run |-> out_pins[5] == $past(e[5]))
    else $error("pin 5 wrong");
  tx_pins_a: assert property (run |-> out_pins[7:6] == $past(e[7:6]))
    else $error("pins 6 and 7 wrong");
  ptr_reset_a: assert property (ptr_cmd_a |=> !mode_ptr_chan_a)
    else $error("pointer not back at register one");
  ptr_advance_a: assert property (acc_one_a |=> mode_ptr_chan_a)
    else $error("pointer did not advance");
  ptr_hold_a: assert property (mode_ptr_chan_a && !cmd_wr_chan_a
    |=> mode_ptr_chan_a)
    else $error("pointer left register two");
endmodule
bind dopm_output_mux dopm_checker dopm_checker_i (.*);

// [verification/dopm_pin_load.sv]
// Purpose: circuits hanging on the parallel output pins
// Assumes: pins are push-pull flops, never released
// Notes:   no pull-up needed while the pins are always driven
`timescale 1ns/1ps
module dopm_pin_load (
  // pins from the device
  input  wire logic [7:0] out_pins,
  // levels seen by the attached circuits
  output wire logic [7:0] pin_seen
);
  // attached logic reads each pin straight off the wire
  assign pin_seen = out_pins;
endmodule

// [verification/test_duart_output_port_mux_mr_pointer.sv]
// Purpose: self-checking bench for the output pin mux and mode pointer
// Assumes: pins lag sources and config by one clock
// Notes:   inputs change only on the falling edge
`timescale 1ns/1ps
module test_duart_output_port_mux_mr_pointer;
  logic clk_sys = 1'b0, reset = 1'b1, output_pin_config_reg_wr = 1'b0, acr_wr = 1'b0;
  logic mode_wr_chan_a = 1'b0, mode_wr_chan_b = 1'b0, opr_set = 1'b0;
  logic mode_rd_chan_a = 1'b0, mode_rd_chan_b = 1'b0, opr_clr = 1'b0;
  logic cmd_wr_chan_a = 1'b0, cmd_wr_chan_b = 1'b0, csr_wr_chan_b = 1'b0;
  logic csr_wr_chan_a = 1'b0;
  logic [7:0] mode_wdata_chan_a = 8'h00, mode_wdata_chan_b = 8'h00;
  logic [7:0] cmd_wdata = 8'h00, csr_wdata = 8'h00, output_pin_config_reg_wdata = 8'h00;
  logic [7:0] acr_wdata = 8'h00, opr_bits = 8'h00, pin_seen, out_pins;
  logic [7:0] mode_rdata_chan_a, mode_rdata_chan_b, clock_select_chan_a;
  logic [7:0] clock_select_chan_b, output_pin_config, aux_control;
  logic [7:0] output_latch, mode_one_chan_a, mode_two_chan_a;
  logic [7:0] mode_one_chan_b, mode_two_chan_b;
  logic mode_ptr_chan_a, mode_ptr_chan_b, rx_ready_chan_a, rx_ready_chan_b;
  logic rx_fifo_full_chan_a, rx_fifo_full_chan_b, tx_ready_chan_a;
  logic tx_ready_chan_b, rx_rts_chan_a, tx_rts_chan_a, rx_rts_chan_b;
  logic tx_rts_chan_b, counter_ready_out, timer_out, tx_clock_chan_a_16x;
  logic tx_clock_chan_a, rx_clock_chan_a, tx_clock_chan_b, rx_clock_chan_b;
  int   n_mismatch = 0;
  int   comparisons = 0;

  dopm_output_mux dopm_output_mux_i (.*);
  dopm_pin_load dopm_pin_load_i (.out_pins(out_pins), .pin_seen(pin_seen));

  initial forever #5 clk_sys = ~clk_sys;

  // strobe one cycle, then a spare cycle so no strobe is set twice at once
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
    @(negedge clk_sys);
  endtask
  task automatic chk(input string nm, input logic [7:0] ex, got);
    comparisons++;
    if (got !== ex) begin
      $display("wrong value %s: expected %h, seen %h", nm, ex, got);
      n_mismatch++;
    end
  endtask
  task automatic cmd(input logic ch, input logic [7:0] d);
    cmd_wdata = d;
    if (ch) pulse(cmd_wr_chan_b);
    else pulse(cmd_wr_chan_a);
  endtask
  task automatic mw(input logic ch, input logic [7:0] d);
    mode_wdata_chan_a = d;
    mode_wdata_chan_b = d;
    if (ch) pulse(mode_wr_chan_b);
    else pulse(mode_wr_chan_a);
  endtask
  // bit 0 is channel a ready, bit 16 the channel b receive clock
  task automatic set_src(input logic [16:0] s);
    {rx_clock_chan_b, tx_clock_chan_b, rx_clock_chan_a, tx_clock_chan_a,
     tx_clock_chan_a_16x, timer_out, counter_ready_out, tx_rts_chan_b,
     rx_rts_chan_b, tx_rts_chan_a, rx_rts_chan_a, tx_ready_chan_b,
     tx_ready_chan_a, rx_fifo_full_chan_b, rx_fifo_full_chan_a,
     rx_ready_chan_b, rx_ready_chan_a} = s;
  endtask
  // quiet the channels, reprogram, then read the pins a clock later
  task automatic pin(input logic [7:0] oc, ac, m1a, m2a, m1b, m2b,
                     input logic [16:0] s, input logic [7:0] ex);
    // receivers and transmitters of both channels idle first
    for (int i = 0; i < 4; i++) cmd(i[1], i[0] ? 8'h30 : 8'h20);
    output_pin_config_reg_wdata = oc;
    pulse(output_pin_config_reg_wr);
    acr_wdata = ac;
    pulse(acr_wr);
    for (int i = 0; i < 2; i++) cmd(i[0], 8'h10);
    mw(1'b0, m1a);
    mw(1'b0, m2a);
    mw(1'b1, m1b);
    mw(1'b1, m2b);
    set_src(s);
    @(negedge clk_sys);
    chk("pins", ex, pin_seen);
    chk("pin config", oc, output_pin_config);
    chk("aux control", ac, aux_control);
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // watchdog well past the under two hundred cycles the tests need
  initial begin
    #50000;
    n_mismatch++;
    tally_and_finish;
  end

  initial begin
    set_src(17'h00000);
    repeat (8) @(negedge clk_sys);
    reset = 1'b0;
    chk("pins", 8'h00, pin_seen);
    chk("pointer a", 8'h00, {7'h00, mode_ptr_chan_a});
    // back-to-back writes land in register one, then two
    mode_wdata_chan_a = 8'h5a;
    mode_wr_chan_a = 1'b1;
    @(negedge clk_sys);
    mode_wdata_chan_a = 8'ha5;
    @(negedge clk_sys);
    mode_wr_chan_a = 1'b0;
    chk("mode one a", 8'h5a, mode_one_chan_a);
    chk("mode two a", 8'ha5, mode_two_chan_a);
    chk("pointer b", 8'h00, {7'h00, mode_ptr_chan_b});
    cmd(1'b0, 8'h40);
    chk("pointer a", 8'h01, {7'h00, mode_ptr_chan_a});
    cmd(1'b0, 8'h10);
    chk("read a", 8'h5a, mode_rdata_chan_a);
    pulse(mode_rd_chan_a);
    chk("read a", 8'ha5, mode_rdata_chan_a);
    mw(1'b1, 8'h3c);
    chk("mode one b", 8'h3c, mode_one_chan_b);
    chk("pointer b", 8'h01, {7'h00, mode_ptr_chan_b});
    chk("read b", 8'h00, mode_rdata_chan_b);
    csr_wdata = 8'hee;
    pulse(csr_wr_chan_a);
    chk("clock sel a", 8'hee, clock_select_chan_a);
    chk("clock sel b", 8'h00, clock_select_chan_b);
    opr_bits = 8'hff;
    pulse(opr_set);
    opr_bits = 8'h0f;
    pulse(opr_clr);
    chk("latch", 8'hf0, output_latch);
    $display("pointer and register test done");
    pin(8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 17'h1ffff, 8'hf0);
    pin(8'hf5, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 17'h01429, 8'h9c);
    pin(8'hf5, 8'h40, 8'h40, 8'h00, 8'h40, 8'h00, 17'h02419, 8'h60);
    pin(8'h0a, 8'h00, 8'h80, 8'h00, 8'h00, 8'h20, 17'h16240, 8'hf7);
    pin(8'h0f, 8'h00, 8'h00, 8'h20, 8'h80, 8'h00, 17'h0c140, 8'hf6);
    pin(8'h04, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 17'h00800, 8'hf8);
    $display("pin test done");
    tally_and_finish;
  end
endmodule
